// ===== logic/kwp_key_wakeup_ports.sv
`timescale 1ns/1ps
`include "kwp_map.svh"
// Overview of operation
// RQ1: strap high pulls up, low pulls down
// RQ2: data registers at 28 and 29
// RQ3: direction bit 1 output, 0 input
// RQ4: option selects edge or start detect on G6
// RQ5: option makes G6 and G7 open-drain
// RQ6: start needs SDA fall while SCL high
// RQ7: G6 enable gates edge or start interrupt
// RQ8: enable bit 1 enables, 0 disables wake
// RQ9: G flags except 6 set by falling edge
// RQ10: write one clears flag, zero keeps it
// RQ11: G flag bit 7 reads zero
// RQ12: G flag 6 records edge or start
// RQ13: H flags set by falling edge
// RQ14: filter active only in stop mode
// RQ15: filter oscillator starts on enabled edge
// RQ16: two of three samples validate level
// RQ17: one filter shared by all enabled inputs
// RQ18: sources space pulses beyond minimum interval
// RQ19: interrupt when flag and enable both set
// RQ20: falling edge wakes through unclocked path in stop
// RQ21: pins pass two flip-flops before edge detect
module kwp_key_wakeup_ports #(
  parameter int FILT_PERIOD = `KWP_FILT_PERIOD_NS / `KWP_CLK_PERIOD_NS
) (
  input  wire logic                 sys_clk_in,
  input  wire logic                 reset_in,
  input  wire kwp_pkg::kwp_axi_req_t axi_req_in,
  output kwp_pkg::kwp_axi_rsp_t     axi_rsp_out,
  input  wire kwp_pkg::kwp_pair_t   pin_in,
  output kwp_pkg::kwp_pair_t        pin_out,
  output kwp_pkg::kwp_pair_t        pin_oe_out,
  input  wire logic                 port_g_pull_select_strap_in,
  input  wire logic                 port_h_pull_select_strap_in,
  output kwp_pkg::kwp_pair_t        pull_up_en_out,
  output kwp_pkg::kwp_pair_t        pull_down_en_out,
  input  wire logic                 stop_mode_in,
  output logic                      wake_irq_out
);
  import kwp_pkg::*;

  localparam int FP = (FILT_PERIOD < 3) ? 3 : FILT_PERIOD;

  kwp_pair_t       data_r, dir_r, en_r, flg_r, flg_nxt;
  logic            i2c_wake_option_r;
  kwp_pair_t       sync1_r, sync2_r, prev_r;
  logic            strap_g1_r, strap_g2_r, strap_h1_r, strap_h2_r;
  logic            stop1_r, stop2_r;
  kwp_axi_rsp_t    rsp_r;
  logic            aw_held_r, w_held_r;
  logic [7:0]      aw_addr_r;
  logic [31:0]     w_data_r;
  logic [3:0]      w_strb_r;
  kwp_filt_state_t filt_state_r;
  logic [7:0]      filt_cnt_r;
  logic [1:0]      filt_votes_r;
  kwp_pair_t       filt_armed_r;
  kwp_pair_t       fall, trig, filt_set, clear_mask;
  logic            start_det, do_write, do_read;
  logic [7:0]      wr_byte;

  // register index from a byte address; unaligned low bits are ignored
  function automatic logic [7:0] reg_index(input logic [7:0] addr);
    return {2'b00, addr[7:2]};
  endfunction

  // printed index times four gives the byte address
  function automatic logic match(input logic [7:0] addr, input logic [7:0] idx);
    return addr == {idx[5:0], 2'b00};
  endfunction

  // pin synchronisers
  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      sync1_r <= '0;
      sync2_r <= '0;
      prev_r  <= '0;
    end else begin
      sync1_r <= pin_in; // RQ21
      sync2_r <= sync1_r; // RQ21
      prev_r  <= sync2_r;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      strap_g1_r <= 1'b0;
      strap_g2_r <= 1'b0;
      strap_h1_r <= 1'b0;
      strap_h2_r <= 1'b0;
      stop1_r    <= 1'b0;
      stop2_r    <= 1'b0;
    end else begin
      strap_g1_r <= port_g_pull_select_strap_in;
      strap_g2_r <= strap_g1_r;
      strap_h1_r <= port_h_pull_select_strap_in;
      strap_h2_r <= strap_h1_r;
      stop1_r    <= stop_mode_in;
      stop2_r    <= stop1_r;
    end
  end

  always_comb begin
    pull_up_en_out.g   = {8{strap_g2_r}}; // RQ1
    pull_up_en_out.h   = {8{strap_h2_r}}; // RQ1
    pull_down_en_out.g = {8{~strap_g2_r}}; // RQ1
    pull_down_en_out.h = {8{~strap_h2_r}}; // RQ1
  end

  // pin drivers; open-drain drives only a low level
  always_comb begin
    pin_out    = data_r;
    pin_oe_out = dir_r; // RQ3
    if (i2c_wake_option_r) begin
      pin_out.g[`KWP_BIT_SDA]    = 1'b0; // RQ5
      pin_out.g[`KWP_BIT_SCL]    = 1'b0; // RQ5
      pin_oe_out.g[`KWP_BIT_SDA] = dir_r.g[`KWP_BIT_SDA] & ~data_r.g[`KWP_BIT_SDA]; // RQ5
      pin_oe_out.g[`KWP_BIT_SCL] = dir_r.g[`KWP_BIT_SCL] & ~data_r.g[`KWP_BIT_SCL]; // RQ5
    end
  end

  // edge detection on synchronised pins
  always_comb begin
    fall      = prev_r & ~sync2_r; // RQ9 RQ13 RQ20
    start_det = fall.g[`KWP_BIT_SDA] & sync2_r.g[`KWP_BIT_SCL]; // RQ6
    trig      = fall;
    trig.g[`KWP_BIT_SCL] = 1'b0;
    // g6 is either a plain edge or a start condition
    trig.g[`KWP_BIT_SDA] = i2c_wake_option_r ? start_det : fall.g[`KWP_BIT_SDA]; // RQ4 RQ7 RQ12
  end

  // shared majority-vote filter, only while in stop
  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      filt_state_r   <= KWP_FILT_IDLE;
      filt_cnt_r     <= '0;
      filt_votes_r   <= '0;
      filt_armed_r   <= '0;
    end else begin
      unique case (filt_state_r)
        KWP_FILT_IDLE: begin
          filt_cnt_r     <= '0;
          filt_votes_r   <= '0;
          if (stop2_r && |(trig & en_r)) begin // RQ15 RQ17
            filt_state_r <= KWP_FILT_SAMPLE;
            filt_armed_r <= trig & en_r; // RQ17
          end
        end
        KWP_FILT_SAMPLE: begin
          filt_armed_r <= filt_armed_r | (trig & en_r); // RQ17
          filt_cnt_r   <= filt_cnt_r + 8'h01;
          if (filt_cnt_r == 8'(FP / 3) || filt_cnt_r == 8'(2 * FP / 3)
              || filt_cnt_r == 8'(FP - 1)) begin
            // asserted level is low for a falling-edge trigger
            if (|(filt_armed_r & ~sync2_r & en_r))
              filt_votes_r <= filt_votes_r + 2'h1; // RQ16
          end
          if (filt_cnt_r == 8'(FP - 1) || !stop2_r) begin
            filt_state_r <= KWP_FILT_IDLE;
            filt_armed_r <= '0;
          end
        end
        default: filt_state_r <= KWP_FILT_IDLE;
      endcase
    end
  end

  always_comb begin
    filt_set = '0;
    // two of three samples at the triggering level
    if (filt_state_r == KWP_FILT_SAMPLE && filt_cnt_r == 8'(FP - 1)) begin
      if ((filt_votes_r + (|(filt_armed_r & ~sync2_r & en_r) ? 2'h1 : 2'h0)) >= 2'h2)
        filt_set = filt_armed_r & en_r; // RQ16
    end
  end

  // axi4-lite slave
  assign do_write = aw_held_r && w_held_r && !rsp_r.bvalid;
  assign do_read  = axi_req_in.arvalid && rsp_r.arready && !rsp_r.rvalid;

  always_comb begin
    wr_byte    = w_strb_r[0] ? w_data_r[7:0] : 8'h00;
    clear_mask = '0;
    if (do_write && w_strb_r[0]) begin
      if (match(aw_addr_r, `KWP_IDX_G_WAKE_FLG)) clear_mask.g = wr_byte; // RQ10
      if (match(aw_addr_r, `KWP_IDX_H_WAKE_FLG)) clear_mask.h = wr_byte; // RQ10
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      aw_held_r <= 1'b0;
      w_held_r  <= 1'b0;
      aw_addr_r <= '0;
      w_data_r  <= '0;
      w_strb_r  <= '0;
    end else begin
      if (axi_req_in.awvalid && !aw_held_r) begin
        aw_held_r <= 1'b1;
        aw_addr_r <= axi_req_in.awaddr;
      end else if (do_write) begin
        aw_held_r <= 1'b0;
      end
      if (axi_req_in.wvalid && !w_held_r) begin
        w_held_r <= 1'b1;
        w_data_r <= axi_req_in.wdata;
        w_strb_r <= axi_req_in.wstrb;
      end else if (do_write) begin
        w_held_r <= 1'b0;
      end
    end
  end

  // control registers
  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      data_r            <= '{`KWP_RST_BYTE, `KWP_RST_BYTE};
      dir_r             <= '{`KWP_RST_BYTE, `KWP_RST_BYTE};
      en_r              <= '{`KWP_RST_BYTE, `KWP_RST_BYTE};
      i2c_wake_option_r <= 1'b0;
    end else if (do_write && w_strb_r[0]) begin
      if (match(aw_addr_r, `KWP_IDX_G_DATA)) data_r.g <= wr_byte; // RQ2
      if (match(aw_addr_r, `KWP_IDX_H_DATA)) data_r.h <= wr_byte; // RQ2
      if (match(aw_addr_r, `KWP_IDX_G_DIR))  dir_r.g  <= wr_byte; // RQ3
      if (match(aw_addr_r, `KWP_IDX_H_DIR))  dir_r.h  <= wr_byte; // RQ3
      if (match(aw_addr_r, `KWP_IDX_G_WAKE_EN)) begin
        en_r.g            <= {1'b0, wr_byte[6:0]}; // RQ8
        i2c_wake_option_r <= wr_byte[`KWP_BIT_I2C_WAKE]; // RQ4
      end
      if (match(aw_addr_r, `KWP_IDX_H_WAKE_EN)) en_r.h <= wr_byte; // RQ8
      if (match(aw_addr_r, `KWP_IDX_OPTION))
        i2c_wake_option_r <= wr_byte[`KWP_BIT_I2C_WAKE];
    end
  end

  // flags: set wins over a simultaneous clear
  always_comb begin
    flg_nxt = flg_r & ~clear_mask; // RQ10
    if (stop2_r)
      flg_nxt = flg_nxt | filt_set; // RQ14
    else
      flg_nxt = flg_nxt | trig; // RQ9 RQ13 RQ14
    flg_nxt.g = flg_nxt.g & `KWP_RST_FLG_G_MASK; // RQ11
  end

  always_ff @(posedge sys_clk_in) begin
    if (reset_in) flg_r <= '0;
    else          flg_r <= flg_nxt;
  end

  // stop wake path: enabled low pin level reaches the request without a flop
  assign wake_irq_out = (|(flg_r & en_r)) // RQ19
                      | (stop_mode_in & |(~pin_in & en_r)); // RQ20

  // responses
  function automatic logic [7:0] read_byte(input logic [7:0] addr);
    logic [7:0] v;
    v = 8'h00;
    if (match(addr, `KWP_IDX_G_DATA))     v = data_r.g; // RQ2
    if (match(addr, `KWP_IDX_H_DATA))     v = data_r.h;
    if (match(addr, `KWP_IDX_G_DIR))      v = dir_r.g;
    if (match(addr, `KWP_IDX_H_DIR))      v = dir_r.h;
    if (match(addr, `KWP_IDX_G_WAKE_EN))  v = {i2c_wake_option_r, en_r.g[6:0]};
    if (match(addr, `KWP_IDX_H_WAKE_EN))  v = en_r.h;
    if (match(addr, `KWP_IDX_G_WAKE_FLG)) v = {1'b0, flg_r.g[6:0]}; // RQ11
    if (match(addr, `KWP_IDX_H_WAKE_FLG)) v = flg_r.h;
    if (match(addr, `KWP_IDX_OPTION))     v = {i2c_wake_option_r, 7'h00};
    if (match(addr, `KWP_IDX_STATUS))     v = {7'h00, stop2_r};
    return v;
  endfunction

  function automatic logic mapped(input logic [7:0] addr);
    return reg_index(addr) >= `KWP_IDX_G_DATA && reg_index(addr) <= `KWP_IDX_STATUS
           && addr[1:0] == 2'b00;
  endfunction

  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      rsp_r <= '0;
      rsp_r.arready <= 1'b1;
    end else begin
      if (do_write) begin
        rsp_r.bvalid <= 1'b1;
        rsp_r.bresp  <= mapped(aw_addr_r) ? `KWP_AXI_OKAY : `KWP_AXI_SLVERR;
      end else if (axi_req_in.bready) begin
        rsp_r.bvalid <= 1'b0;
      end
      if (do_read) begin
        rsp_r.rvalid  <= 1'b1;
        rsp_r.arready <= 1'b0;
        rsp_r.rdata   <= {24'h000000, read_byte(axi_req_in.araddr)};
        rsp_r.rresp   <= mapped(axi_req_in.araddr) ? `KWP_AXI_OKAY : `KWP_AXI_SLVERR;
      end else if (rsp_r.rvalid && axi_req_in.rready) begin
        rsp_r.rvalid  <= 1'b0;
        rsp_r.arready <= 1'b1;
      end
    end
  end

  always_comb begin
    axi_rsp_out         = rsp_r;
    axi_rsp_out.awready = !aw_held_r;
    axi_rsp_out.wready  = !w_held_r;
  end

  // checks
  property p_flag_set;
    @(posedge sys_clk_in) disable iff (reset_in)
      (!stop2_r && trig.h[0]) |=> flg_r.h[0];
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("h0 flag not set"); // RQ13

  property p_g7_zero;
    @(posedge sys_clk_in) disable iff (reset_in) !flg_r.g[7];
  endproperty
  a_g7_zero: assert property (p_g7_zero) else $error("g7 flag set"); // RQ11

  property p_irq;
    @(posedge sys_clk_in) disable iff (reset_in)
      (|(flg_r & en_r)) |-> wake_irq_out;
  endproperty
  a_irq: assert property (p_irq) else $error("irq missing"); // RQ19

  property p_start_scl;
    @(posedge sys_clk_in) disable iff (reset_in)
      (i2c_wake_option_r && !stop2_r && !$past(flg_r.g[6]) && flg_r.g[6]
       && $past(clear_mask.g[6]) == 1'b0) |-> $past(sync2_r.g[7]);
  endproperty
  a_start_scl: assert property (p_start_scl) else $error("start without scl high"); // RQ6

  property p_no_filter_outside_stop;
    @(posedge sys_clk_in) disable iff (reset_in)
      !stop2_r |=> (filt_state_r == KWP_FILT_IDLE);
  endproperty
  a_no_filter_outside_stop: assert property (p_no_filter_outside_stop) // RQ14
    else $error("filter running outside stop");

  // in stop only the filter may raise a flag
  property p_stop_gated;
    @(posedge sys_clk_in) disable iff (reset_in)
      (stop2_r && filt_state_r == KWP_FILT_IDLE && !flg_r.h[1]) |=> !flg_r.h[1];
  endproperty
  a_stop_gated: assert property (p_stop_gated) else $error("raw edge set flag in stop"); // RQ14

  property p_g_flag_set;
    @(posedge sys_clk_in) disable iff (reset_in)
      (!stop2_r && trig.g[0]) |=> flg_r.g[0];
  endproperty
  a_g_flag_set: assert property (p_g_flag_set) else $error("g0 flag not set"); // RQ9

  property p_scl_low;
    @(posedge sys_clk_in) disable iff (reset_in)
      (i2c_wake_option_r && !stop2_r && fall.g[6] && !sync2_r.g[7] && !flg_r.g[6])
      |=> !flg_r.g[6];
  endproperty
  a_scl_low: assert property (p_scl_low) else $error("start with scl low"); // RQ6

  property p_irq_quiet;
    @(posedge sys_clk_in) disable iff (reset_in)
      (!stop_mode_in && !(|(flg_r & en_r))) |-> !wake_irq_out;
  endproperty
  a_irq_quiet: assert property (p_irq_quiet) else $error("spurious irq"); // RQ19

  property p_w1c;
    @(posedge sys_clk_in) disable iff (reset_in)
      (clear_mask.h[1] && !stop2_r && !trig.h[1]) |=> !flg_r.h[1];
  endproperty
  a_w1c: assert property (p_w1c) else $error("flag not cleared"); // RQ10

  property p_dir;
    @(posedge sys_clk_in) disable iff (reset_in) pin_oe_out.h == dir_r.h;
  endproperty
  a_dir: assert property (p_dir) else $error("direction mismatch"); // RQ3

  property p_od;
    @(posedge sys_clk_in) disable iff (reset_in)
      i2c_wake_option_r |-> (pin_out.g[7:6] == 2'b00);
  endproperty
  a_od: assert property (p_od) else $error("open drain drives high"); // RQ5

endmodule

// ===== include/kwp_map.svh
`ifndef KWP_MAP_SVH
`define KWP_MAP_SVH

// register indices; byte address is index * 4 since every register is word aligned
`define KWP_IDX_G_DATA      8'h28
`define KWP_IDX_H_DATA      8'h29
`define KWP_IDX_G_DIR       8'h2a
`define KWP_IDX_H_DIR       8'h2b
`define KWP_IDX_G_WAKE_EN   8'h2c
`define KWP_IDX_H_WAKE_EN   8'h2d
`define KWP_IDX_G_WAKE_FLG  8'h2e
`define KWP_IDX_H_WAKE_FLG  8'h2f
`define KWP_IDX_OPTION      8'h30
`define KWP_IDX_STATUS      8'h31

// field positions
`define KWP_BIT_I2C_WAKE    7
`define KWP_BIT_SDA         6
`define KWP_BIT_SCL         7
`define KWP_BIT_STOP        0

// reset values
`define KWP_RST_BYTE        8'h00
`define KWP_RST_FLG_G_MASK  8'h7f

// filter oscillator: period in ns, sampled three times per period
`define KWP_FILT_PERIOD_NS  90
`define KWP_CLK_PERIOD_NS   10

`define KWP_AXI_OKAY        2'b00
`define KWP_AXI_SLVERR      2'b10

`endif

// ===== include/kwp_pkg.sv
package kwp_pkg;

  typedef struct packed {
    logic [7:0] g;
    logic [7:0] h;
  } kwp_pair_t;

  typedef struct packed {
    logic [7:0] awaddr;
    logic       awvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic       wvalid;
    logic       bready;
    logic [7:0] araddr;
    logic       arvalid;
    logic       rready;
  } kwp_axi_req_t;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } kwp_axi_rsp_t;

  typedef enum logic [1:0] {
    KWP_FILT_IDLE,
    KWP_FILT_SAMPLE
  } kwp_filt_state_t;

endpackage

// ===== tb/kwp_pin_model.sv
`timescale 1ns/1ps
// switches and lines hanging on the port pins
module kwp_pin_model
  import kwp_pkg::*;
(
  input  wire logic               sys_clk_in,
  input  wire kwp_pkg::kwp_pair_t dut_out_in,
  input  wire kwp_pkg::kwp_pair_t dut_oe_in,
  input  wire kwp_pkg::kwp_pair_t pull_up_in,
  input  wire kwp_pkg::kwp_pair_t pull_down_in,
  input  wire kwp_pkg::kwp_pair_t ext_lvl_in,
  input  wire kwp_pkg::kwp_pair_t ext_drv_in,
  output kwp_pkg::kwp_pair_t      pin_lvl_out
);
  logic [15:0] flip_r = 16'h55aa;
  logic [15:0] oe;
  logic [15:0] drv;
  logic [15:0] pu;
  logic [15:0] pd;

  // a floating pin must not settle to a convenient level
  always @(posedge sys_clk_in) begin
    flip_r <= ~flip_r;
  end

  assign oe  = dut_oe_in;
  assign drv = ~oe & ext_drv_in;
  assign pu  = ~oe & ~drv & pull_up_in;
  assign pd  = ~oe & ~drv & pull_down_in;
  // pin driver wins over the switch; open-drain pins only drive when oe is set
  assign pin_lvl_out = (oe & dut_out_in) | (drv & ext_lvl_in) | pu |
                       (~oe & ~drv & ~pu & ~pd & flip_r);
endmodule

// ===== tb/kwp_key_wakeup_ports_test.sv
`timescale 1ns/1ps
`include "kwp_map.svh"
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin error_cnt++; \
  $display("Error %s expected %h seen %h", nm, e, g); end end
module kwp_key_wakeup_ports_test;
  import kwp_pkg::*;
  typedef struct packed {
    logic [7:0] idx;
    logic [7:0] wd;
    logic [7:0] rd;
    logic [1:0] resp;
  } kwp_row_t;
  localparam int FP = 9;
  logic          sys_clk_in = 1'b0;
  logic          reset_in = 1'b1;
  kwp_axi_req_t  req;
  kwp_axi_rsp_t  rsp;
  kwp_pair_t     pin_lvl, pin_o, pin_oe, pu, pd, ext_lvl, ext_drv;
  logic          strap_g, strap_h, stop, irq;
  logic [1:0]    rs;
  logic [7:0]    rd8;
  int            error_cnt = 0;
  int            checks = 0;
  int            cyc = 0;
  kwp_row_t rows [10] = '{
    '{`KWP_IDX_G_DATA, 8'h5a, 8'h5a, `KWP_AXI_OKAY},
    '{`KWP_IDX_H_DATA, 8'ha5, 8'ha5, `KWP_AXI_OKAY},
    '{`KWP_IDX_G_DIR, 8'h3c, 8'h3c, `KWP_AXI_OKAY},
    '{`KWP_IDX_H_DIR, 8'hc3, 8'hc3, `KWP_AXI_OKAY},
    '{`KWP_IDX_G_WAKE_EN, 8'h7f, 8'h7f, `KWP_AXI_OKAY},
    '{`KWP_IDX_H_WAKE_EN, 8'h00, 8'h00, `KWP_AXI_OKAY},
    '{`KWP_IDX_G_WAKE_FLG, 8'hff, 8'h00, `KWP_AXI_OKAY},
    '{`KWP_IDX_OPTION, 8'h80, 8'h80, `KWP_AXI_OKAY},
    '{`KWP_IDX_STATUS, 8'hff, 8'h00, `KWP_AXI_OKAY},
    '{8'h3f, 8'h77, 8'h00, `KWP_AXI_SLVERR}
  };

  kwp_key_wakeup_ports #(.FILT_PERIOD(FP)) dut_u (
    .sys_clk_in(sys_clk_in), .reset_in(reset_in), .axi_req_in(req), .axi_rsp_out(rsp),
    .pin_in(pin_lvl), .pin_out(pin_o), .pin_oe_out(pin_oe),
    .port_g_pull_select_strap_in(strap_g), .port_h_pull_select_strap_in(strap_h),
    .pull_up_en_out(pu), .pull_down_en_out(pd), .stop_mode_in(stop), .wake_irq_out(irq));

  kwp_pin_model pin_u (
    .sys_clk_in(sys_clk_in), .dut_out_in(pin_o), .dut_oe_in(pin_oe), .pull_up_in(pu),
    .pull_down_in(pd), .ext_lvl_in(ext_lvl), .ext_drv_in(ext_drv), .pin_lvl_out(pin_lvl));

  always #5 sys_clk_in = ~sys_clk_in;

  task automatic wrap_up;
    $display("checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  always @(posedge sys_clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      error_cnt++;
      wrap_up();
    end
  end

  task automatic wr(input logic [7:0] idx, input logic [7:0] d, output logic [1:0] r);
    int n;
    n = 0;
    req.awaddr <= {idx[5:0], 2'b00};
    req.awvalid <= 1'b1;
    req.wdata <= {24'h0, d};
    req.wstrb <= 4'h1;
    req.wvalid <= 1'b1;
    req.bready <= 1'b1;
    do begin
      @(posedge sys_clk_in);
      n++;
      if (req.awvalid && rsp.awready) req.awvalid <= 1'b0;
      if (req.wvalid && rsp.wready) req.wvalid <= 1'b0;
    end while (!rsp.bvalid && n < 50);
    `CHK("bvalid", 1'b1, rsp.bvalid)
    r = rsp.bresp;
    req.bready <= 1'b0;
    @(posedge sys_clk_in);
  endtask

  task automatic rd(input logic [7:0] idx, output logic [7:0] d, output logic [1:0] r);
    int n;
    n = 0;
    req.araddr <= {idx[5:0], 2'b00};
    req.arvalid <= 1'b1;
    req.rready <= 1'b1;
    do begin
      @(posedge sys_clk_in);
      n++;
      if (req.arvalid && rsp.arready) req.arvalid <= 1'b0;
    end while (!rsp.rvalid && n < 50);
    `CHK("rvalid", 1'b1, rsp.rvalid)
    d = rsp.rdata[7:0];
    r = rsp.rresp;
    req.rready <= 1'b0;
    @(posedge sys_clk_in);
  endtask

  task automatic rdchk(input logic [7:0] idx, input logic [7:0] e);
    logic [7:0] d;
    logic [1:0] r;
    rd(idx, d, r);
    `CHK($sformatf("reg %h", idx), e, d)
  endtask

  // pins 0..7 are port h, 8..15 port g
  task automatic pin(input int b, input logic v, input int w);
    ext_lvl[b] <= v;
    repeat (w) @(posedge sys_clk_in);
  endtask

  initial begin
    req = '0;
    ext_lvl = 16'hffff;
    ext_drv = 16'hffff;
    strap_g = 1'b1;
    strap_h = 1'b0;
    stop = 1'b0;
    repeat (4) @(posedge sys_clk_in);
    reset_in <= 1'b0;
    @(posedge sys_clk_in);
    foreach (rows[i]) begin
      wr(rows[i].idx, rows[i].wd, rs);
      `CHK("write resp", rows[i].resp, rs)
      rd(rows[i].idx, rd8, rs);
      `CHK("read data", rows[i].rd, rd8)
      `CHK("read resp", rows[i].resp, rs)
    end
    `CHK("g oe", 8'h3c, pin_oe.g)
    `CHK("h oe", 8'hc3, pin_oe.h)
    `CHK("h out", 8'ha5, pin_o.h)
    $display("test table done");
    // reset in mid-run brings every register back
    reset_in <= 1'b1;
    repeat (4) @(posedge sys_clk_in);
    reset_in <= 1'b0;
    @(posedge sys_clk_in);
    for (int a = 0; a < 8; a++) rdchk(8'(8'h28 + a), 8'h00);
    `CHK("oe after reset", 16'h0000, pin_oe)
    $display("test reset done");
    `CHK("pull up", 16'hff00, pu)
    `CHK("pull down", 16'h00ff, pd)
    strap_g <= 1'b0;
    strap_h <= 1'b1;
    repeat (5) @(posedge sys_clk_in);
    `CHK("pull up", 16'h00ff, pu)
    `CHK("pull down", 16'hff00, pd)
    $display("test pulls done");
    wr(`KWP_IDX_H_WAKE_EN, 8'h01, rs);
    pin(0, 0, 4);
    pin(8, 0, 4);
    pin(15, 0, 6);
    rdchk(`KWP_IDX_H_WAKE_FLG, 8'h01);
    rdchk(`KWP_IDX_G_WAKE_FLG, 8'h01);
    `CHK("irq", 1'b1, irq)
    wr(`KWP_IDX_H_WAKE_FLG, 8'h01, rs);
    rdchk(`KWP_IDX_H_WAKE_FLG, 8'h00);
    `CHK("irq", 1'b0, irq)
    wr(`KWP_IDX_G_WAKE_FLG, 8'h00, rs);
    rdchk(`KWP_IDX_G_WAKE_FLG, 8'h01);
    wr(`KWP_IDX_G_WAKE_FLG, 8'h01, rs);
    ext_lvl <= 16'hffff;
    $display("test edges done");
    wr(`KWP_IDX_G_WAKE_EN, 8'hc0, rs);
    wr(`KWP_IDX_G_DIR, 8'hc0, rs);
    wr(`KWP_IDX_G_DATA, 8'h40, rs);
    `CHK("g6 g7 oe", 2'b10, pin_oe.g[7:6])
    `CHK("g6 g7 out", 2'b00, pin_o.g[7:6])
    wr(`KWP_IDX_G_DIR, 8'h00, rs);
    pin(14, 0, 6);
    rdchk(`KWP_IDX_G_WAKE_FLG, 8'h40);
    `CHK("irq", 1'b1, irq)
    pin(14, 1, 4);
    wr(`KWP_IDX_G_WAKE_FLG, 8'h40, rs);
    pin(15, 0, 4);
    pin(14, 0, 6);
    pin(14, 1, 4);
    pin(15, 1, 4);
    rdchk(`KWP_IDX_G_WAKE_FLG, 8'h00);
    wr(`KWP_IDX_G_WAKE_EN, 8'h40, rs);
    pin(15, 0, 4);
    pin(14, 0, 6);
    rdchk(`KWP_IDX_G_WAKE_FLG, 8'h40);
    ext_lvl <= 16'hffff;
    wr(`KWP_IDX_G_WAKE_FLG, 8'h40, rs);
    wr(`KWP_IDX_G_WAKE_EN, 8'h00, rs);
    $display("test i2c done");
    wr(`KWP_IDX_H_WAKE_EN, 8'h02, rs);
    stop <= 1'b1;
    repeat (4) @(posedge sys_clk_in);
    // pulses spaced well beyond the filter period
    pin(1, 0, 1);
    pin(1, 1, 30);
    rdchk(`KWP_IDX_H_WAKE_FLG, 8'h00);
    pin(2, 0, 30);
    pin(2, 1, 30);
    rdchk(`KWP_IDX_H_WAKE_FLG, 8'h00);
    pin(1, 0, 3);
    `CHK("stop irq", 1'b1, irq)
    repeat (20) @(posedge sys_clk_in);
    pin(1, 1, 4);
    rdchk(`KWP_IDX_H_WAKE_FLG, 8'h02);
    wr(`KWP_IDX_H_WAKE_FLG, 8'hff, rs);
    stop <= 1'b0;
    repeat (4) @(posedge sys_clk_in);
    pin(1, 0, 1);
    pin(1, 1, 6);
    rdchk(`KWP_IDX_H_WAKE_FLG, 8'h02);
    $display("test stop done");
    wrap_up();
  end
endmodule
